// *** src/chb_pkg.sv ***
// constants shared by the charger host register bank
package chb_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_CTRL = 8'h12;
  localparam logic [7:0] CMD_ICHG = 8'h14;
  localparam logic [7:0] CMD_VCHG = 8'h15;
  localparam logic [7:0] CMD_ADC_CUR_CMP = 8'h25;
  localparam logic [7:0] CMD_ADC_SYS_BAT = 8'h26;
  localparam logic [7:0] CMD_REV_VOLT = 8'h3B;
  localparam logic [7:0] CMD_REV_CUR = 8'h3C;
  localparam logic [7:0] CMD_VIN_FLOOR = 8'h3D;
  localparam logic [7:0] CMD_SYS_FLOOR = 8'h3E;
  localparam logic [7:0] CMD_HOST_ILIM = 8'h3F;
  localparam logic [7:0] CMD_MAKER_ID = 8'hFE;
  localparam logic [7:0] CMD_PART_ID = 8'hFF;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'hE20E;
  localparam int LP_BIT = 15;
  localparam int WD_LSB = 13;
  localparam int WD_W = 2;
  localparam int ICHG_LSB = 6;
  localparam int ICHG_W = 7;
  localparam int VCHG_LSB = 4;
  localparam int VCHG_W = 11;
  localparam int REVV_LSB = 6;
  localparam int REVV_W = 8;
  localparam int REVI_LSB = 8;
  localparam int REVI_W = 7;
  localparam int VIN_LSB = 6;
  localparam int VIN_W = 8;
  localparam int SYSF_LSB = 8;
  localparam int SYSF_W = 6;
  localparam int HILIM_LSB = 8;
  localparam int HILIM_W = 6;
  localparam logic [6:0] ICHG_RST = 7'h00;
  localparam logic [10:0] VCHG_RST = 11'h106;
  localparam logic [7:0] REVV_RST = 8'h00;
  localparam logic [6:0] REVI_RST = 7'h00;
  localparam logic [7:0] VIN_RST = 8'h00;
  localparam logic [5:0] SYSF_RST = 6'h0E;
  localparam logic [5:0] HILIM_RST = 6'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ---------------------------------------------------------------
  // watchdog timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint WD_FAST_S = 5;
  localparam longint WD_MID_S = 88;
  localparam longint WD_SLOW_S = 175;
  localparam logic [34:0] WD_FAST_CYC = 35'(WD_FAST_S * CLK_HZ);
  localparam logic [34:0] WD_MID_CYC = 35'(WD_MID_S * CLK_HZ);
  localparam logic [34:0] WD_SLOW_CYC = 35'(WD_SLOW_S * CLK_HZ);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WLO, ST_WHI, ST_RLO, ST_RHI, ST_SKIP
  } chb_state_t;

endpackage

// *** src/chb_register_bank.sv ***
// smbus register bank with charge watchdog and low power gating
`timescale 1ns/1ps
`default_nettype none
module chb_register_bank
  import chb_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h09,
  // arbitrary value
  parameter logic [15:0] MAKER_ID = 16'h1234,
  // arbitrary value
  parameter logic [15:0] PART_ID = 16'h5678,
  parameter logic [34:0] WD_FAST = WD_FAST_CYC,
  parameter logic [34:0] WD_MID = WD_MID_CYC,
  parameter logic [34:0] WD_SLOW = WD_SLOW_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic smb_clk,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe,
  input wire logic battery_only,
  input wire logic aux_cmp_enable_a,
  input wire logic aux_cmp_enable_b,
  input wire logic prochot_cfg_enable,
  input wire logic monitor_cfg_enable,
  input wire logic comparator_cfg_enable,
  input wire logic adc_cfg_enable,
  input wire logic [7:0] adc_input_current_sense,
  input wire logic [7:0] adc_comparator_input,
  input wire logic [7:0] adc_system_rail_voltage,
  input wire logic [7:0] adc_battery_voltage,
  output logic [15:0] charger_control_word,
  output logic [6:0] charge_current_setting,
  output logic [10:0] charge_voltage_setting,
  output logic [7:0] reverse_output_voltage_setpoint,
  output logic [6:0] reverse_output_current_limit,
  output logic [7:0] input_voltage_floor,
  output logic [5:0] system_voltage_floor,
  output logic [5:0] host_input_current_limit,
  output logic charge_suspended,
  output logic prochot_enable,
  output logic monitor_buffer_enable,
  output logic comparator_enable,
  output logic adc_enable
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    chb_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [7:0] wlo;
    logic [15:0] tx;
    logic ack;
    logic oe;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic batt_m;
    logic batt_s;
    logic [15:0] ctrl;
    logic [6:0] ichg;
    logic [10:0] vchg;
    logic [7:0] revv;
    logic [6:0] revi;
    logic [7:0] vin;
    logic [5:0] sysf;
    logic [5:0] hilim;
    logic [34:0] wd_cnt;
    logic wd_expired;
    logic prochot_en;
    logic monitor_en;
    logic cmp_en;
    logic adc_en;
  } chb_reg_t;

  localparam chb_reg_t ST_RST = '{
    state: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, cmd: 8'h00, wlo: 8'h00,
    tx: 16'h0000, ack: 1'b0, oe: 1'b0,
    scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
    batt_m: 1'b0, batt_s: 1'b0,
    ctrl: CTRL_RST, ichg: ICHG_RST, vchg: VCHG_RST, revv: REVV_RST,
    revi: REVI_RST, vin: VIN_RST, sysf: SYSF_RST, hilim: HILIM_RST,
    wd_cnt: WD_SLOW - 35'h1, wd_expired: 1'b0,
    prochot_en: 1'b0, monitor_en: 1'b0, cmp_en: 1'b0, adc_en: 1'b0
  };

  chb_reg_t st_ff;
  chb_reg_t nxt_st;
  logic link_bit_ff;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic rx_phase;
  logic tx_phase;
  logic wr_now;
  logic [15:0] wr_word;
  logic wd_qual;
  logic low_power;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // reload value, one less than the period in cycles
  function automatic logic [34:0] wd_reload(input logic [1:0] p);
    logic [34:0] r;
    r = 35'h0;
    unique case (p)
      2'b00: r = 35'h0;
      2'b01: r = WD_FAST - 35'h1;
      2'b10: r = WD_MID - 35'h1;
      2'b11: r = WD_SLOW - 35'h1;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] rd_word(input logic [7:0] c,
                                          input chb_reg_t s);
    logic [15:0] r;
    r = 16'h0000;
    unique case (c)
      CMD_CTRL: r = s.ctrl;
      CMD_ICHG: r = 16'(s.ichg) << ICHG_LSB;
      CMD_VCHG: r = 16'(s.vchg) << VCHG_LSB;
      CMD_ADC_CUR_CMP: begin
        r = {adc_input_current_sense, adc_comparator_input};
      end
      CMD_ADC_SYS_BAT: begin
        r = {adc_system_rail_voltage, adc_battery_voltage};
      end
      CMD_REV_VOLT: r = 16'(s.revv) << REVV_LSB;
      CMD_REV_CUR: r = 16'(s.revi) << REVI_LSB;
      CMD_VIN_FLOOR: r = 16'(s.vin) << VIN_LSB;
      CMD_SYS_FLOOR: r = 16'(s.sysf) << SYSF_LSB;
      CMD_HOST_ILIM: r = 16'(s.hilim) << HILIM_LSB;
      CMD_MAKER_ID: r = MAKER_ID;
      CMD_PART_ID: r = PART_ID;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // link side: data bit caught on the bus clock rise
  // ---------------------------------------------------------------
  // held until the next rise, read only after a synchronised rise
  always_ff @(posedge smb_clk) begin
    link_bit_ff <= smb_data_in;
  end

  assign start_cond = st_ff.scl_s & st_ff.scl_d & st_ff.sda_d & ~st_ff.sda_s;
  assign stop_cond = st_ff.scl_s & st_ff.scl_d & ~st_ff.sda_d & st_ff.sda_s;
  assign scl_rise = st_ff.scl_s & ~st_ff.scl_d;
  assign scl_fall = ~st_ff.scl_s & st_ff.scl_d;
  assign rx_phase = (st_ff.state == ST_ADDR) || (st_ff.state == ST_CMD) ||
                    (st_ff.state == ST_WLO) || (st_ff.state == ST_WHI);
  assign tx_phase = (st_ff.state == ST_RLO) || (st_ff.state == ST_RHI);
  assign low_power = st_ff.ctrl[LP_BIT] & st_ff.batt_s;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [2:0] tx_idx;
    logic [1:0] period;
    rx_byte = {st_ff.shreg[6:0], link_bit_ff};
    tx_byte = (st_ff.state == ST_RLO) ? st_ff.tx[7:0] : st_ff.tx[15:8];
    tx_idx = 3'(4'h7 - st_ff.bitcnt);
    period = 2'b00;
    nxt_st = st_ff;
    wr_now = 1'b0;
    wr_word = 16'h0000;
    wd_qual = 1'b0;
    nxt_st.scl_m = smb_clk;
    nxt_st.scl_s = st_ff.scl_m;
    nxt_st.scl_d = st_ff.scl_s;
    nxt_st.sda_m = smb_data_in;
    nxt_st.sda_s = st_ff.sda_m;
    nxt_st.sda_d = st_ff.sda_s;
    nxt_st.batt_m = battery_only;
    nxt_st.batt_s = st_ff.batt_m;

    // bus framing; repeated start keeps the command byte
    if (start_cond) begin
      nxt_st.state = ST_ADDR;
      nxt_st.bitcnt = 4'h0;
      nxt_st.ack = 1'b0;
      nxt_st.oe = 1'b0;
    end else if (stop_cond) begin
      nxt_st.state = ST_IDLE;
      nxt_st.bitcnt = 4'h0;
      nxt_st.oe = 1'b0;
    end else begin
      if (scl_rise && st_ff.state != ST_IDLE) begin
        if (st_ff.bitcnt < BYTE_BITS) begin
          nxt_st.shreg = rx_byte;
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          if (st_ff.bitcnt == BYTE_BITS - 4'h1 && rx_phase) begin
            unique case (st_ff.state)
              ST_ADDR: nxt_st.ack = (rx_byte[7:1] == SLAVE_ADDR);
              ST_CMD: begin
                nxt_st.ack = 1'b1;
                nxt_st.cmd = rx_byte;
              end
              ST_WLO: begin
                nxt_st.ack = 1'b1;
                nxt_st.wlo = rx_byte;
              end
              ST_WHI: begin
                nxt_st.ack = 1'b1;
                wr_now = 1'b1;
                wr_word = {rx_byte, st_ff.wlo};
              end
              ST_IDLE, ST_RLO, ST_RHI, ST_SKIP: nxt_st.ack = 1'b0;
            endcase
          end
        end else begin
          // acknowledge slot just clocked
          nxt_st.bitcnt = 4'h0;
          nxt_st.ack = 1'b0;
          unique case (st_ff.state)
            ST_ADDR: begin
              if (!st_ff.ack) begin
                nxt_st.state = ST_SKIP;
              end else if (st_ff.shreg[0]) begin
                nxt_st.state = ST_RLO;
                nxt_st.tx = rd_word(st_ff.cmd, st_ff);
              end else begin
                nxt_st.state = ST_CMD;
              end
            end
            ST_CMD: nxt_st.state = ST_WLO;
            ST_WLO: nxt_st.state = ST_WHI;
            ST_WHI: nxt_st.state = ST_SKIP;
            // master nack ends the read
            ST_RLO: nxt_st.state = link_bit_ff ? ST_SKIP : ST_RHI;
            ST_RHI: nxt_st.state = ST_SKIP;
            ST_IDLE, ST_SKIP: nxt_st.state = st_ff.state;
          endcase
        end
      end
      if (scl_fall) begin
        nxt_st.oe = (rx_phase && st_ff.bitcnt == BYTE_BITS && st_ff.ack) ||
                    (tx_phase && st_ff.bitcnt < BYTE_BITS &&
                     !tx_byte[tx_idx]);
      end
    end

    // register writes; read-only and unmapped words are dropped
    if (wr_now) begin
      unique case (st_ff.cmd)
        CMD_CTRL: nxt_st.ctrl = wr_word;
        CMD_ICHG: nxt_st.ichg = wr_word[ICHG_LSB +: ICHG_W];
        CMD_VCHG: nxt_st.vchg = wr_word[VCHG_LSB +: VCHG_W];
        CMD_REV_VOLT: nxt_st.revv = wr_word[REVV_LSB +: REVV_W];
        CMD_REV_CUR: nxt_st.revi = wr_word[REVI_LSB +: REVI_W];
        CMD_VIN_FLOOR: nxt_st.vin = wr_word[VIN_LSB +: VIN_W];
        CMD_SYS_FLOOR: nxt_st.sysf = wr_word[SYSF_LSB +: SYSF_W];
        CMD_HOST_ILIM: begin
          nxt_st.hilim = wr_word[HILIM_LSB +: HILIM_W];
        end
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end

    // watchdog; a qualifying write wins over expiry in the same cycle
    wd_qual = wr_now && (st_ff.cmd == CMD_CTRL || st_ff.cmd == CMD_ICHG ||
                         st_ff.cmd == CMD_VCHG);
    period = nxt_st.ctrl[WD_LSB +: WD_W];
    if (wd_qual) begin
      nxt_st.wd_expired = 1'b0;
      nxt_st.wd_cnt = wd_reload(period);
    end else if (period != 2'b00 && !st_ff.wd_expired) begin
      if (st_ff.wd_cnt == 35'h0) begin
        nxt_st.wd_expired = 1'b1;
        nxt_st.ichg = ICHG_RST;
      end else begin
        nxt_st.wd_cnt = st_ff.wd_cnt - 35'h1;
      end
    end

    // low power gating of the analog helpers
    nxt_st.prochot_en = ~low_power & prochot_cfg_enable;
    nxt_st.monitor_en = ~low_power & monitor_cfg_enable;
    nxt_st.adc_en = ~low_power & adc_cfg_enable;
    nxt_st.cmp_en = low_power ? (aux_cmp_enable_a | aux_cmp_enable_b)
                              : comparator_cfg_enable;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign smb_data_out = 1'b0;
  assign smb_data_oe = st_ff.oe;
  assign charger_control_word = st_ff.ctrl;
  assign charge_current_setting = st_ff.ichg;
  assign charge_voltage_setting = st_ff.vchg;
  assign reverse_output_voltage_setpoint = st_ff.revv;
  assign reverse_output_current_limit = st_ff.revi;
  assign input_voltage_floor = st_ff.vin;
  assign system_voltage_floor = st_ff.sysf;
  assign host_input_current_limit = st_ff.hilim;
  assign charge_suspended = st_ff.wd_expired;
  assign prochot_enable = st_ff.prochot_en;
  assign monitor_buffer_enable = st_ff.monitor_en;
  assign comparator_enable = st_ff.cmp_en;
  assign adc_enable = st_ff.adc_en;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_ctrl_reset;
    $fell(reset) |-> st_ff.ctrl == CTRL_RST &&
                     st_ff.wd_cnt == WD_SLOW - 35'h1;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset)
    else $error("control word or watchdog wrong after reset");

  property p_wd_fast;
    wr_now && st_ff.cmd == CMD_CTRL && wr_word[WD_LSB +: WD_W] == 2'b01
      |=> st_ff.wd_cnt == WD_FAST - 35'h1 ##1
          st_ff.wd_cnt == WD_FAST - 35'h2;
  endproperty
  a_wd_fast: assert property (p_wd_fast)
    else $error("short watchdog period not loaded");

  property p_wd_force;
    !wd_qual && st_ff.ctrl[WD_LSB +: WD_W] != 2'b00 && !st_ff.wd_expired &&
      st_ff.wd_cnt == 35'h0 |=> st_ff.ichg == ICHG_RST && st_ff.wd_expired;
  endproperty
  a_wd_force: assert property (p_wd_force)
    else $error("expiry did not force charge current to zero");

  property p_wd_restart;
    st_ff.wd_expired && wd_qual |=> !st_ff.wd_expired;
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("watchdog not restarted by host write");

  property p_wd_stop;
    wr_now && st_ff.cmd == CMD_CTRL && wr_word[WD_LSB +: WD_W] == 2'b00
      |=> (st_ff.wd_cnt == 35'h0 && !st_ff.wd_expired)[*3];
  endproperty
  a_wd_stop: assert property (p_wd_stop)
    else $error("watchdog kept running after disable");

  property p_lp_off;
    low_power |=> !st_ff.adc_en && !st_ff.prochot_en && !st_ff.monitor_en;
  endproperty
  a_lp_off: assert property (p_lp_off)
    else $error("helper left on in low power mode");

  property p_lp_cmp;
    low_power && (aux_cmp_enable_a || aux_cmp_enable_b) |=> st_ff.cmp_en;
  endproperty
  a_lp_cmp: assert property (p_lp_cmp)
    else $error("comparator not enabled by aux bits");

  property p_perf;
    !st_ff.ctrl[LP_BIT] |=> st_ff.prochot_en == $past(prochot_cfg_enable) &&
                            st_ff.cmp_en == $past(comparator_cfg_enable);
  endproperty
  a_perf: assert property (p_perf)
    else $error("performance mode does not follow settings");

  property p_ichg_store;
    wr_now && st_ff.cmd == CMD_ICHG
      |=> st_ff.ichg == $past(wr_word[ICHG_LSB +: ICHG_W]);
  endproperty
  a_ichg_store: assert property (p_ichg_store)
    else $error("charge current write not stored");

  property p_id_read;
    scl_rise && !start_cond && !stop_cond && st_ff.state == ST_ADDR &&
      st_ff.bitcnt == BYTE_BITS && st_ff.ack && st_ff.shreg[0] &&
      st_ff.cmd == CMD_PART_ID |=> st_ff.tx == PART_ID &&
                                  st_ff.state == ST_RLO;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity word not loaded for read");

  property p_c_expire;
    $rose(st_ff.wd_expired);
  endproperty
  c_expire: cover property (p_c_expire);

  property p_c_read;
    st_ff.state == ST_RHI ##1 st_ff.state == ST_SKIP;
  endproperty
  c_read: cover property (p_c_read);

  property p_c_write;
    wr_now && st_ff.cmd == CMD_VCHG;
  endproperty
  c_write: cover property (p_c_write);

  property p_c_lp_cmp;
    low_power && st_ff.cmp_en;
  endproperty
  c_lp_cmp: cover property (p_c_lp_cmp);

endmodule
`default_nettype wire

// *** bench/chb_smb_master.sv ***
// smbus master model for the charger register bank
`timescale 1ns/1ps
`default_nettype none
module chb_smb_master #(
  parameter logic [6:0] ADDR = 7'h09
) (
  output logic smb_clk,
  output logic data_oe,
  input wire logic data_line,
  output logic [15:0] rd_data
);
  // ---------------------------------------------------------------
  // bit and word transfers on a 15 ns base clock
  // ---------------------------------------------------------------
  logic lclk;
  event rd_ev;
  initial begin
    lclk = 1'b0;
    smb_clk = 1'b1;
    data_oe = 1'b0;
    rd_data = 16'h0000;
  end
  always #7.5 lclk = ~lclk;
  task automatic ph(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // clock rests high between frames; data moves well after the fall
  task automatic start();
    ph(4);
    data_oe = 1'b0;
    ph(20);
    smb_clk = 1'b1;
    ph(20);
    data_oe = 1'b1;
    ph(20);
    smb_clk = 1'b0;
  endtask
  task automatic stop();
    ph(4);
    data_oe = 1'b1;
    ph(20);
    smb_clk = 1'b1;
    ph(20);
    data_oe = 1'b0;
    ph(20);
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic b9,
                       output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      ph(4);
      data_oe = (i >= 0) ? ~tx[i] : ~b9;
      ph(20);
      smb_clk = 1'b1;
      ph(20);
      if (i >= 0) begin
        rx[i] = data_line;
      end else begin
        ack = data_line;
      end
      smb_clk = 1'b0;
    end
  endtask
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] w,
                            output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, rx, a0);
    xbyte(cmd, 1'b1, rx, a1);
    xbyte(w[7:0], 1'b1, rx, a2);
    xbyte(w[15:8], 1'b1, rx, a3);
    stop();
    ok = ~(a0 | a1 | a2 | a3);
  endtask
  task automatic read_word(input logic [7:0] cmd);
    logic [7:0] lo, hi, rx;
    logic a;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, rx, a);
    xbyte(cmd, 1'b1, rx, a);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, rx, a);
    xbyte(8'hFF, 1'b0, lo, a);
    xbyte(8'hFF, 1'b1, hi, a);
    stop();
    rd_data = {hi, lo};
    -> rd_ev;
  endtask
endmodule
`default_nettype wire

// *** bench/charger_host_register_bank_tb_top.sv ***
// self-checking bench for the charger host register bank
`timescale 1ns/1ps
`default_nettype none
module charger_host_register_bank_tb_top;
  import chb_pkg::*;
  // ---------------------------------------------------------------
  // setup, checks and scenarios
  // ---------------------------------------------------------------
  localparam int WF = 3600;
  localparam int WM = 4800;
  localparam int WS = 6000;
  // arbitrary identity values
  localparam logic [15:0] ID_MAKER = 16'h1234;
  localparam logic [15:0] ID_PART = 16'h5678;
  localparam logic [7:0] CMDS [5] = '{CMD_REV_VOLT, CMD_REV_CUR,
    CMD_VIN_FLOOR, CMD_SYS_FLOOR, CMD_HOST_ILIM};
  localparam int LSBS [5] = '{REVV_LSB, REVI_LSB, VIN_LSB, SYSF_LSB,
    HILIM_LSB};
  localparam int WDS [5] = '{REVV_W, REVI_W, VIN_W, SYSF_W, HILIM_W};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic battery_only = 1'b0;
  logic aux_a = 1'b0;
  logic aux_b = 1'b0;
  logic [3:0] cfg = 4'h0;
  logic [31:0] adc = 32'h00000000;
  logic smb_clk, mst_oe, dev_oe, dev_out, sda;
  logic [15:0] ctrl, rd_word;
  logic [6:0] ichg, revi;
  logic [10:0] vchg;
  logic [7:0] revv, vin;
  logic [5:0] sysf, hilim;
  logic susp, en_hot, en_mon, en_cmp, en_adc;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] exp_q [$];
  assign sda = (dev_oe ? dev_out : 1'b1) & ~mst_oe;
  always #4 clk = ~clk;
  chb_register_bank #(.MAKER_ID(ID_MAKER), .PART_ID(ID_PART),
    .WD_FAST(35'(WF)), .WD_MID(35'(WM)), .WD_SLOW(35'(WS))
  ) i_chb_register_bank (.clk(clk), .reset(reset), .smb_clk(smb_clk),
    .smb_data_in(sda), .smb_data_out(dev_out), .smb_data_oe(dev_oe),
    .battery_only(battery_only), .aux_cmp_enable_a(aux_a),
    .aux_cmp_enable_b(aux_b), .prochot_cfg_enable(cfg[0]),
    .monitor_cfg_enable(cfg[1]), .comparator_cfg_enable(cfg[2]),
    .adc_cfg_enable(cfg[3]), .adc_input_current_sense(adc[31:24]),
    .adc_comparator_input(adc[23:16]), .adc_system_rail_voltage(adc[15:8]),
    .adc_battery_voltage(adc[7:0]), .charger_control_word(ctrl),
    .charge_current_setting(ichg), .charge_voltage_setting(vchg),
    .reverse_output_voltage_setpoint(revv),
    .reverse_output_current_limit(revi), .input_voltage_floor(vin),
    .system_voltage_floor(sysf), .host_input_current_limit(hilim),
    .charge_suspended(susp), .prochot_enable(en_hot),
    .monitor_buffer_enable(en_mon), .comparator_enable(en_cmp),
    .adc_enable(en_adc));
  chb_smb_master i_chb_smb_master (.smb_clk(smb_clk), .data_oe(mst_oe),
    .data_line(sda), .rd_data(rd_word));
  task automatic conclude();
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
    logic ok;
    i_chb_smb_master.write_word(cmd, w, ok);
    @(negedge clk);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    exp_q.push_back(exp);
    i_chb_smb_master.read_word(cmd);
  endtask
  task automatic wait_susp(input int lo, input int hi);
    int n;
    n = 0;
    while (susp !== 1'b1 && n < hi) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, susp}, 16'h0001);
    chk({15'h0000, n >= lo}, 16'h0001);
    chk({9'h000, ichg}, 16'h0000);
  endtask
  task automatic lp_run(input logic lp_bit);
    logic [6:0] r;
    logic [15:0] e;
    for (int k = 0; k < 8; k++) begin
      r = 7'($urandom);
      @(posedge clk);
      battery_only <= r[0];
      aux_a <= r[1];
      aux_b <= r[2];
      cfg <= r[6:3];
      repeat (6) @(negedge clk);
      e = (lp_bit & r[0]) ? {14'h0000, r[1] | r[2], 1'b0}
                          : {12'h000, r[3], r[4], r[5], r[6]};
      chk({12'h000, en_hot, en_mon, en_cmp, en_adc}, e);
    end
  endtask
  function automatic logic [15:0] port_of(input int i);
    case (i)
      0: return 16'(revv);
      1: return 16'(revi);
      2: return 16'(vin);
      3: return 16'(sysf);
      default: return 16'(hilim);
    endcase
  endfunction
  always @(i_chb_smb_master.rd_ev) begin
    if (exp_q.size() == 0) begin
      $display("unexpected at %0t: read with nothing noted", $time);
      fail_count++;
    end else begin
      // let the port copy of the read word settle first
      @(negedge clk);
      chk(rd_word, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 97000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    logic [15:0] v;
    logic [6:0] ic;
    void'($urandom(32'h03e0));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(ctrl, CTRL_RST);
    chk({9'h000, ichg}, 16'h0000);
    chk({5'h00, vchg}, {5'h00, VCHG_RST});
    chk({10'h000, sysf}, {10'h000, SYSF_RST});
    wait_susp(WS - 4, WS + 4);
    rd(CMD_CTRL, CTRL_RST);
    wr(CMD_CTRL, 16'hC20E);
    chk({15'h0000, susp}, 16'h0000);
    ic = 7'($urandom) | 7'h01;
    wr(CMD_ICHG, {3'h0, ic, 6'h00});
    chk({9'h000, ichg}, {9'h000, ic});
    wait_susp(WM - 400, WM + 4);
    wr(CMD_CTRL, 16'hA20E);
    for (int j = 0; j < 3; j++) begin
      v = 16'($urandom) & 16'h07FF;
      wr(CMD_VCHG, v << VCHG_LSB);
      chk({5'h00, vchg}, v);
      chk({15'h0000, susp}, 16'h0000);
      if (j == 1) begin
        wait_susp(WF - 400, WF + 4);
      end
    end
    wr(CMD_CTRL, 16'h020E);
    repeat (WF + 400) @(negedge clk);
    chk({15'h0000, susp}, 16'h0000);
    lp_run(1'b0);
    for (int i = 0; i < 5; i++) begin
      v = 16'($urandom) & ((16'h0001 << WDS[i]) - 16'h0001);
      wr(CMDS[i], v << LSBS[i]);
      chk(port_of(i), v);
    end
    rd(CMD_HOST_ILIM, v << HILIM_LSB);
    wr(CMD_MAKER_ID, 16'($urandom));
    rd(CMD_MAKER_ID, ID_MAKER);
    rd(CMD_PART_ID, ID_PART);
    rd(8'h50, 16'h0000);
    @(posedge clk);
    adc <= $urandom;
    @(negedge clk);
    rd(CMD_ADC_CUR_CMP, adc[31:16]);
    rd(CMD_ADC_SYS_BAT, adc[15:0]);
    wr(CMD_CTRL, 16'h820E);
    lp_run(1'b1);
    @(negedge clk);
    chk(16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
